/* rtl/sci_lin_params.svh */
// Register offsets, field positions, reset values and bit-time counts
// for the serial line status and control block.
// Assumes byte addresses on a 32-bit Wishbone data bus, one word per register.
`ifndef SCI_LIN_PARAMS_SVH
`define SCI_LIN_PARAMS_SVH

// Register byte offsets
`define OFF_RX_LINE_STATUS_CTL   5'h00
`define OFF_NINTH_BIT_DIR_CTL    5'h04
`define OFF_FORMAT_CTL           5'h08
`define OFF_SERIAL_DATA          5'h0C
`define OFF_BAUD_DIV             5'h10
`define OFF_IRQ_STATUS           5'h14
`define OFF_IRQ_MASK             5'h18
`define OFF_LINE_STATUS          5'h1C

// Status/control register 2 field positions
`define S2_LIN_BREAK_FLAG        7
`define S2_RX_EDGE_FLAG          6
`define S2_RX_INVERT             4
`define S2_WAKE_QUIET_SEL        3
`define S2_LONG_BREAK_TX         2
`define S2_LIN_BREAK_DET_EN      1
`define S2_RX_ACTIVE_FLAG        0

// Control register 3 field positions
`define C3_RX_NINTH_BIT          7
`define C3_TX_NINTH_BIT          6
`define C3_TX_PIN_DIRECTION      5
`define C3_TX_INVERT             4

// Format control field positions
`define FMT_NINE_BIT             0
`define FMT_LOOP_MODE            1
`define FMT_SINGLE_WIRE_SRC      2
`define FMT_RX_STANDBY           3
`define FMT_SEND_BREAK           4

// Interrupt event positions, except that ev_set puts idle at bit 2 and receive full at bit 3
`define EV_LIN_BREAK             0
`define EV_RX_EDGE               1
`define EV_RX_FULL               2
`define EV_IDLE                  3
`define EV_FRAMING               4
`define EV_TX_DONE               5
`define EV_WIDTH                 6

// Reset values
`define RST_S2                   8'h00
`define RST_C3                   8'h00
`define RST_FORMAT               8'h00
`define RST_BAUD_DIV             16'h015B
`define RST_MASK                 6'h00

// Lengths in bit times (one more in nine-bit format)
`define TX_BREAK_SHORT           4'hA
`define TX_BREAK_LONG            4'hD
`define RX_BREAK_SHORT           4'hA
`define RX_BREAK_LIN             4'hB
`define CHAR_BITS                4'hA

`endif

/* rtl/sci_lin_pkg.sv */
// Types shared by the serial line status and control block.
// Assumes the constants header supplies offsets and field positions.
package sci_lin_pkg;

   // Status/control register 2 as stored
   typedef struct packed {
      logic lin_break_flag;
      logic rx_edge_flag;
      logic rx_invert;
      logic wake_quiet_flag_select;
      logic long_break_tx;
      logic lin_break_detect_enable;
      logic receiver_active_flag;
   } s2_t;

   // Control register 3 as stored
   typedef struct packed {
      logic rx_ninth_bit;
      logic tx_ninth_bit;
      logic tx_pin_direction;
      logic tx_invert;
   } c3_t;

   // Frame format and line routing
   typedef struct packed {
      logic nine_bit;
      logic loop_mode_select;
      logic single_wire_source;
      logic receiver_standby;
   } fmt_t;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_BREAK} tx_state_t;

endpackage : sci_lin_pkg

/* rtl/sci_lin_break_status_ctl.sv */
// Serial line status/control block: LIN break, edge, idle, ninth bits,
// inversion, break length and single-wire pin direction, with a small NRZ engine.
// Assumes Wishbone classic master on ref_clk and pins synchronous to ref_clk.
//
// Notes on behaviour
// - Break flag sets on LIN break, W1C
// - Edge flag on active receive edge, W1C
// - Receive inversion applies to every receive purpose
// - Waking idle sets idle flag only if selected; idle event always
// - Transmit break 10/11 or 13/14 bits
// - Framing check ignores long break select
// - Detect break at 10/11 or 11/12
// - LIN detect blocks framing and full flags
// - Active flag: start bit sets, idle clears
// - Ninth received bit readable in control 3 bit 7
// - Single-wire pin direction from direction bit
// - Idle character length 10 or 11 bits
// - Transmit inversion flips transmitted output
`timescale 1ns/1ps
`include "sci_lin_params.svh"

module sci_lin_break_status_ctl
(
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   input  wire logic        rxd_i,
   input  wire logic        txd_i,
   output logic             txd_o,
   output logic             txd_oe
);

   sci_lin_pkg::s2_t      s2_reg;         // Status/control 2
   sci_lin_pkg::c3_t      c3_reg;         // Control 3
   sci_lin_pkg::fmt_t     fmt_reg;        // Format and routing
   logic [15:0]           baud_reg;       // Cycles per bit minus one
   logic [7:0]            rx_data_reg;    // Buffered receive byte
   logic                  rx_full_reg;    // Receive buffer full
   logic                  idle_flag_reg;  // Idle line seen
   logic                  fe_reg;         // Framing error
   logic [`EV_WIDTH-1:0]  ev_reg;         // Sticky interrupt events
   logic [`EV_WIDTH-1:0]  mask_reg;       // Interrupt enables
   logic                  brk_pend_reg;   // Break queued by software
   logic                  tx_line_reg;    // Un-inverted transmit level

   // Bus strobes
   logic bus_req;
   logic wr;
   logic rd;
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr      = bus_req & wb_we_i & wb_sel_i[0];
   assign rd      = bus_req & ~wb_we_i;

   // Per-register write strobes, plus the data read strobe
   logic wr_s2, wr_c3, wr_fmt, wr_data, wr_baud, wr_ev, wr_mask, rd_data;
   assign wr_s2   = wr & (wb_adr_i == `OFF_RX_LINE_STATUS_CTL);
   assign wr_c3   = wr & (wb_adr_i == `OFF_NINTH_BIT_DIR_CTL);
   assign wr_fmt  = wr & (wb_adr_i == `OFF_FORMAT_CTL);
   assign wr_data = wr & (wb_adr_i == `OFF_SERIAL_DATA);
   assign wr_baud = wr & (wb_adr_i == `OFF_BAUD_DIV);
   assign wr_ev   = wr & (wb_adr_i == `OFF_IRQ_STATUS);
   assign wr_mask = wr & (wb_adr_i == `OFF_IRQ_MASK);
   assign rd_data = rd & (wb_adr_i == `OFF_SERIAL_DATA);

   // Receive source: pin, internal loop, or the shared TxD pin
   logic rx_src;
   logic rx_in;
   logic rx_prev_reg;
   always_comb
   begin
      if (fmt_reg.loop_mode_select & fmt_reg.single_wire_source)
         rx_src = txd_i;
      else if (fmt_reg.loop_mode_select)
         rx_src = txd_o;
      else
         rx_src = rxd_i;
   end
   assign rx_in = rx_src ^ s2_reg.rx_invert;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         rx_prev_reg <= 1'b1;
      else
         rx_prev_reg <= rx_in;
   end

   // Active edge is always a falling edge of the corrected level
   logic rx_fall;
   assign rx_fall = rx_prev_reg & ~rx_in;

   // Length of the present line level in whole bit times
   logic [15:0] run_cnt_reg;
   logic [3:0]  run_bits_reg;
   logic        run_tick;
   assign run_tick = (run_cnt_reg == 16'h0000) & (run_bits_reg != 4'hF);

   // Restarts on every level change so breaks and idles time from the edge
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         run_cnt_reg  <= `RST_BAUD_DIV;
         run_bits_reg <= 4'h0;
      end
      else if (rx_in != rx_prev_reg)
      begin
         run_cnt_reg  <= baud_reg;
         run_bits_reg <= 4'h0;
      end
      else if (run_tick)
      begin
         run_cnt_reg  <= baud_reg;
         run_bits_reg <= run_bits_reg + 4'h1;
      end
      else if (run_cnt_reg != 16'h0000)
         run_cnt_reg  <= run_cnt_reg - 16'h0001;
   end

   logic [3:0] brk_thr;
   logic [3:0] char_len;
   assign brk_thr  = (s2_reg.lin_break_detect_enable ? `RX_BREAK_LIN : `RX_BREAK_SHORT)
                     + {3'b000, fmt_reg.nine_bit};
   assign char_len = `CHAR_BITS + {3'b000, fmt_reg.nine_bit};

   logic brk_det;
   logic idle_det;
   assign brk_det  = run_tick & ~rx_in & (run_bits_reg + 4'h1 == brk_thr);
   assign idle_det = run_tick & rx_in & (run_bits_reg + 4'h1 == char_len)
                     & s2_reg.receiver_active_flag;

   // Receive frame engine, samples mid-bit
   sci_lin_pkg::rx_state_t rx_state_reg;
   logic [15:0] rx_cnt_reg;
   logic [3:0]  rx_idx_reg;
   logic [8:0]  rx_shift_reg;
   logic        rx_start;   // Valid start bit confirmed
   logic        rx_done;    // Stop bit sampled
   assign rx_start = (rx_state_reg == sci_lin_pkg::RX_START) & (rx_cnt_reg == 16'h0000) & ~rx_in;
   assign rx_done  = (rx_state_reg == sci_lin_pkg::RX_STOP) & (rx_cnt_reg == 16'h0000);

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_state_reg <= sci_lin_pkg::RX_IDLE;
         rx_cnt_reg   <= 16'h0000;
         rx_idx_reg   <= 4'h0;
         rx_shift_reg <= 9'h000;
      end
      else
      begin
         case (rx_state_reg)
            sci_lin_pkg::RX_IDLE:
            begin
               // Only a fresh edge starts a frame, not a held low
               if (rx_fall)
               begin
                  rx_state_reg <= sci_lin_pkg::RX_START;
                  rx_cnt_reg   <= {1'b0, baud_reg[15:1]};
               end
            end
            sci_lin_pkg::RX_START:
            begin
               if (rx_cnt_reg != 16'h0000)
                  rx_cnt_reg <= rx_cnt_reg - 16'h0001;
               else if (~rx_in)
               begin
                  rx_state_reg <= sci_lin_pkg::RX_DATA;
                  rx_cnt_reg   <= baud_reg;
                  rx_idx_reg   <= 4'h0;
               end
               else
                  rx_state_reg <= sci_lin_pkg::RX_IDLE; // Glitch, not a start
            end
            sci_lin_pkg::RX_DATA:
            begin
               if (rx_cnt_reg != 16'h0000)
                  rx_cnt_reg <= rx_cnt_reg - 16'h0001;
               else
               begin
                  // LSB first; eight-bit frames shift the ninth slot away
                  rx_shift_reg <= {rx_in, rx_shift_reg[8:1]};
                  rx_cnt_reg   <= baud_reg;
                  rx_idx_reg   <= rx_idx_reg + 4'h1;
                  // Last slot is bit 7, or bit 8 in nine-bit frames
                  if (rx_idx_reg == 4'h7 + {3'b000, fmt_reg.nine_bit})
                     rx_state_reg <= sci_lin_pkg::RX_STOP;
               end
            end
            sci_lin_pkg::RX_STOP:
            begin
               if (rx_cnt_reg != 16'h0000)
                  rx_cnt_reg <= rx_cnt_reg - 16'h0001;
               else
                  rx_state_reg <= sci_lin_pkg::RX_IDLE;
            end
            default: rx_state_reg <= sci_lin_pkg::RX_IDLE;
         endcase
      end
   end

   // Received byte aligned whatever the frame width
   logic [8:0] rx_word;
   assign rx_word = fmt_reg.nine_bit ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};

   // Delivery blocked while LIN detect on
   logic deliver;
   assign deliver = rx_done & ~s2_reg.lin_break_detect_enable & ~fmt_reg.receiver_standby & ~rx_full_reg;

   // Receive buffer and its full and framing flags
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_data_reg   <= 8'h00;
         rx_full_reg   <= 1'b0;
         fe_reg        <= 1'b0;
      end
      else if (deliver)
      begin
         rx_data_reg <= rx_word[7:0];
         rx_full_reg <= 1'b1;
         // Stop check only, break length unused
         fe_reg      <= ~rx_in;
      end
      else if (rd_data)
      begin
         // Reading the data clears the full and framing flags
         rx_full_reg <= 1'b0;
         fe_reg      <= 1'b0;
      end
   end

   // Idle flag, set once per burst of activity
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         idle_flag_reg <= 1'b0;
      else if (idle_det & (~fmt_reg.receiver_standby | s2_reg.wake_quiet_flag_select))
         idle_flag_reg <= 1'b1;
      else if (rd_data)
         idle_flag_reg <= 1'b0;
   end

   // Status/control 2 and its sticky flags
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         {s2_reg.lin_break_flag, s2_reg.rx_edge_flag, s2_reg.rx_invert,
          s2_reg.wake_quiet_flag_select, s2_reg.long_break_tx,
          s2_reg.lin_break_detect_enable, s2_reg.receiver_active_flag} <= 7'h00;
      else
      begin
         if (wr_s2)
         begin
            s2_reg.rx_invert               <= wb_dat_i[`S2_RX_INVERT];
            s2_reg.wake_quiet_flag_select  <= wb_dat_i[`S2_WAKE_QUIET_SEL];
            s2_reg.long_break_tx           <= wb_dat_i[`S2_LONG_BREAK_TX];
            s2_reg.lin_break_detect_enable <= wb_dat_i[`S2_LIN_BREAK_DET_EN];
         end
         if (brk_det & s2_reg.lin_break_detect_enable)
            s2_reg.lin_break_flag <= 1'b1;
         else if (wr_s2 & wb_dat_i[`S2_LIN_BREAK_FLAG])
            s2_reg.lin_break_flag <= 1'b0;
         if (rx_fall)
            s2_reg.rx_edge_flag <= 1'b1;
         else if (wr_s2 & wb_dat_i[`S2_RX_EDGE_FLAG])
            s2_reg.rx_edge_flag <= 1'b0;
         if (rx_start)
            s2_reg.receiver_active_flag <= 1'b1;
         else if (idle_det)
            s2_reg.receiver_active_flag <= 1'b0;
      end
   end

   // Control 3 writable fields, format, divisor and mask
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         c3_reg   <= 4'h0;
         fmt_reg  <= 4'h0;
         baud_reg <= `RST_BAUD_DIV;
         mask_reg <= `RST_MASK;
      end
      else
      begin
         if (wr_c3)
         begin
            c3_reg.tx_ninth_bit     <= wb_dat_i[`C3_TX_NINTH_BIT];
            c3_reg.tx_pin_direction <= wb_dat_i[`C3_TX_PIN_DIRECTION];
            c3_reg.tx_invert        <= wb_dat_i[`C3_TX_INVERT];
         end
         if (deliver)
            c3_reg.rx_ninth_bit <= rx_word[8];
         if (wr_fmt)
            fmt_reg <= {wb_dat_i[`FMT_NINE_BIT], wb_dat_i[`FMT_LOOP_MODE],
                        wb_dat_i[`FMT_SINGLE_WIRE_SRC], wb_dat_i[`FMT_RX_STANDBY]};
         else if (idle_det)
            fmt_reg.receiver_standby <= 1'b0; // Idle wakes the receiver
         if (wr_baud)
            baud_reg <= (wb_dat_i[15:0] == 16'h0000) ? 16'h0001 : wb_dat_i[15:0];
         if (wr_mask)
            mask_reg <= wb_dat_i[`EV_WIDTH-1:0];
      end
   end

   // Transmit engine
   sci_lin_pkg::tx_state_t tx_state_reg;
   logic [15:0] tx_cnt_reg;
   logic [3:0]  tx_left_reg;
   logic [10:0] tx_shift_reg;
   logic        tx_done;
   assign tx_done = (tx_state_reg != sci_lin_pkg::TX_IDLE) & (tx_cnt_reg == 16'h0000)
                    & (tx_left_reg == 4'h1);

   logic [3:0] tx_brk_len;
   assign tx_brk_len = (s2_reg.long_break_tx ? `TX_BREAK_LONG : `TX_BREAK_SHORT)
                       + {3'b000, fmt_reg.nine_bit};

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_state_reg <= sci_lin_pkg::TX_IDLE;
         tx_cnt_reg   <= 16'h0000;
         tx_left_reg  <= 4'h0;
         tx_shift_reg <= 11'h7FF;
         tx_line_reg  <= 1'b1;
         brk_pend_reg <= 1'b0;
      end
      else
      begin
         if (wr_fmt & wb_dat_i[`FMT_SEND_BREAK])
            brk_pend_reg <= 1'b1;
         case (tx_state_reg)
            sci_lin_pkg::TX_IDLE:
            begin
               tx_line_reg <= 1'b1;
               if (brk_pend_reg)
               begin
                  brk_pend_reg <= 1'b0;
                  tx_state_reg <= sci_lin_pkg::TX_BREAK;
                  tx_cnt_reg   <= baud_reg;
                  tx_left_reg  <= tx_brk_len;
                  tx_line_reg  <= 1'b0;
               end
               // Writes while busy are dropped; poll the busy bit first
               else if (wr_data)
               begin
                  tx_state_reg <= sci_lin_pkg::TX_SHIFT;
                  tx_cnt_reg   <= baud_reg;
                  tx_left_reg  <= char_len;
                  tx_line_reg  <= 1'b0;
                  tx_shift_reg <= fmt_reg.nine_bit ? {1'b1, c3_reg.tx_ninth_bit, wb_dat_i[7:0], 1'b0}
                                                   : {2'b11, wb_dat_i[7:0], 1'b0};
               end
            end
            sci_lin_pkg::TX_SHIFT, sci_lin_pkg::TX_BREAK:
            begin
               if (tx_cnt_reg != 16'h0000)
                  tx_cnt_reg <= tx_cnt_reg - 16'h0001;
               else if (tx_done)
               begin
                  tx_state_reg <= sci_lin_pkg::TX_IDLE;
                  tx_line_reg  <= 1'b1;
               end
               else
               begin
                  tx_cnt_reg   <= baud_reg;
                  tx_left_reg  <= tx_left_reg - 4'h1;
                  tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                  tx_line_reg  <= (tx_state_reg == sci_lin_pkg::TX_SHIFT) & tx_shift_reg[1];
               end
            end
            default: tx_state_reg <= sci_lin_pkg::TX_IDLE;
         endcase
      end
   end

   // Pin drive, registered
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         txd_o  <= 1'b1;
         txd_oe <= 1'b1;
      end
      else
      begin
         txd_o  <= tx_line_reg ^ c3_reg.tx_invert;
         txd_oe <= ~(fmt_reg.loop_mode_select & fmt_reg.single_wire_source) | c3_reg.tx_pin_direction;
      end
   end

   // Sticky events; a set in the clear cycle survives
   logic [`EV_WIDTH-1:0] ev_set;
   assign ev_set = {tx_done, deliver & ~rx_in, deliver, idle_det, rx_fall,
                    brk_det & s2_reg.lin_break_detect_enable};

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ev_reg <= `RST_MASK;
         irq_o  <= 1'b0;
      end
      else
      begin
         ev_reg <= (ev_reg & ~({`EV_WIDTH{wr_ev}} & wb_dat_i[`EV_WIDTH-1:0])) | ev_set;
         irq_o  <= |(ev_reg & mask_reg);
      end
   end

   // Bus answer: one wait state, unmapped reads zero
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h0000_0000;
         if (rd)
            case (wb_adr_i)
               `OFF_RX_LINE_STATUS_CTL: wb_dat_o[7:0] <= {s2_reg[6:5], 1'b0, s2_reg[4:0]};
               `OFF_NINTH_BIT_DIR_CTL:  wb_dat_o[7:0] <= {c3_reg, 4'h0};
               `OFF_FORMAT_CTL:         wb_dat_o[7:0] <= {3'h0, brk_pend_reg, fmt_reg[0], fmt_reg[1],
                                                          fmt_reg[2], fmt_reg[3]};
               `OFF_SERIAL_DATA:        wb_dat_o[7:0] <= rx_data_reg;
               `OFF_BAUD_DIV:           wb_dat_o[15:0] <= baud_reg;
               `OFF_IRQ_STATUS:         wb_dat_o[`EV_WIDTH-1:0] <= ev_reg;
               `OFF_IRQ_MASK:           wb_dat_o[`EV_WIDTH-1:0] <= mask_reg;
               `OFF_LINE_STATUS:        wb_dat_o[3:0] <= {tx_state_reg != sci_lin_pkg::TX_IDLE,
                                                          fe_reg, idle_flag_reg, rx_full_reg};
               default:                 wb_dat_o <= 32'h0000_0000;
            endcase
      end
   end

endmodule : sci_lin_break_status_ctl

/* bench/sci_lin_sva.sv */
// Bus and pin checker for the serial status block.
// Assumes a classic single-cycle Wishbone master.
`timescale 1ns/1ps
module sci_lin_sva
(
   input wire logic        ref_clk,
   input wire logic        arst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [4:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        irq_o,
   input wire logic        txd_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   logic       wr;     // Write taken this edge
   logic [5:0] mask_q; // Shadow of interrupt mask
   logic [2:0] oe_q;   // Shadow of loop, source, direction
   logic       oe_exp; // Expected pin drive
   assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
   assign oe_exp = !(oe_q[2] && oe_q[1] && !oe_q[0]);
   // Shadows follow taken writes only
   always_ff @(posedge ref_clk or negedge arst_n)
      if (!arst_n)
      begin
         mask_q <= 6'h00;
         oe_q   <= 3'h0;
      end
      else if (wr && wb_adr_i == 5'h18)
         mask_q <= wb_dat_i[5:0];
      else if (wr && wb_adr_i == 5'h08)
         oe_q[2:1] <= wb_dat_i[1] ? {1'b1, wb_dat_i[2]} : {1'b0, wb_dat_i[2]};
      else if (wr && wb_adr_i == 5'h04)
         oe_q[0] <= wb_dat_i[5];
   sequence s_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rd_ack;
      wb_ack_o && !wb_we_i;
   endsequence
   a_ack_next_cycle: assert property (s_taken |=> wb_ack_o) else $error("ack late");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data leak");
   a_s2_spare_zero: assert property (s_rd_ack ##0 wb_adr_i == 5'h00 |-> !wb_dat_o[5] && wb_dat_o[31:8] == 24'h00_0000)
      else $error("s2 spare bits");
   a_c3_spare_zero: assert property (s_rd_ack ##0 wb_adr_i == 5'h04 |-> wb_dat_o[3:0] == 4'h0)
      else $error("c3 spare bits");
   a_unaligned_zero: assert property (s_rd_ack ##0 wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read");
   a_pin_direction: assert property ($stable(oe_exp) && $past(oe_exp) == $past(oe_exp, 2) |-> txd_oe == oe_exp)
      else $error("pin direction");
   a_irq_masked_off: assert property (mask_q == 6'h00 && $past(mask_q) == 6'h00 |-> !irq_o)
      else $error("irq while masked");
endmodule : sci_lin_sva
bind sci_lin_break_status_ctl sci_lin_sva sva_i (.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .txd_oe(txd_oe));

/* bench/lin_node_model.sv */
// Remote serial node: drives the receive line, watches transmit.
// Assumes a mark-high line and BIT clocks per bit.
`timescale 1ns/1ps
module lin_node_model
#(
   parameter int BIT = 4 // Clocks per bit
)
(
   input  wire logic clk,
   output logic      rxd,
   input  wire logic txd
);
   initial rxd = 1'b1;
   // Hold one level for n bits
   task put(input logic v, input int n);
      rxd <= v;
      repeat (n * BIT) @(posedge clk);
   endtask : put
   // Frame LSB first; pol flips every level
   task send(input logic [8:0] d, input int nb, input logic pol);
      put(pol, 1);
      for (int i = 0; i < nb; i++)
         put(d[i] ^ pol, 1);
      put(!pol, 14);
   endtask : send
   // Sample a frame mid-bit
   task get(output logic [8:0] d, input int nb);
      d = 9'h000;
      while (txd !== 1'b0)
         @(posedge clk);
      repeat (BIT + BIT / 2) @(posedge clk);
      for (int i = 0; i < nb; i++)
      begin
         d[i] = txd;
         repeat (BIT) @(posedge clk);
      end
   endtask : get
   // Length of next low stretch
   task lowlen(output int n);
      n = 0;
      while (txd !== 1'b0)
         @(posedge clk);
      while (txd === 1'b0)
      begin
         @(posedge clk);
         n++;
      end
   endtask : lowlen
endmodule : lin_node_model

/* bench/tb.sv */
// Self-checking bench for the serial status block.
// Assumes the checker is bound and divisor 3 gives 4 clocks a bit.
`timescale 1ns/1ps
module tb;
   logic ref_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, rxd_i, txd_o, txd_oe;
   logic [4:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [8:0]  d9;
   wire         txd_line = txd_oe ? txd_o : 1'b1; // Pulled-up pin
   int          n_mismatch, checks_done, n;
   sci_lin_break_status_ctl DUT (.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_o(irq_o), .rxd_i(rxd_i), .txd_i(txd_line), .txd_o(txd_o), .txd_oe(txd_oe));
   lin_node_model #(.BIT(4)) node (.clk(ref_clk), .rxd(rxd_i), .txd(txd_o));
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task chk(input string w, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", w, e, s);
      end
   endtask : chk
   // One classic cycle, read data into q
   task wb(input logic we, input logic [4:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // No own limit: only the watchdog ends a stalled wait
      do
         @(posedge ref_clk);
      while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
   endtask : wb
   task rd(input logic [4:0] a, input logic [31:0] e, input string w);
      wb(1'b0, a, 32'h0000_0000);
      chk(w, q, e);
   endtask : rd
   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   // Reset values, read-back and an unmapped hole
   task t_regs;
      rd(5'h00, 32'h0000_0000, "s2 reset");
      rd(5'h04, 32'h0000_0000, "c3 reset");
      wb(1'b1, 5'h10, 32'h0000_0003);
      wb(1'b1, 5'h00, 32'h0000_00CF);
      rd(5'h00, 32'h0000_000E, "s2 rw");
      rd(5'h02, 32'h0000_0000, "unmapped");
      $display("test regs done");
   endtask : t_regs
   // LIN detect: 10 low bits pass, 12 flag
   task t_lin;
      wb(1'b1, 5'h00, 32'h0000_0002);
      wb(1'b1, 5'h18, 32'h0000_0001);
      node.put(1'b0, 10);
      node.put(1'b1, 15);
      rd(5'h00, 32'h0000_0042, "short low");
      wb(1'b0, 5'h1C, 32'h0000_0000);
      chk("full blocked", q & 32'h0000_0005, 32'h0000_0000);
      node.put(1'b0, 12);
      node.put(1'b1, 15);
      rd(5'h00, 32'h0000_00C2, "break flag");
      chk("irq up", irq_o, 1'b1);
      wb(1'b1, 5'h14, 32'h0000_003F);
      wb(1'b1, 5'h00, 32'h0000_00C2);
      rd(5'h00, 32'h0000_0002, "w1c");
      chk("irq down", irq_o, 1'b0);
      $display("test lin done");
   endtask : t_lin
   // Inverted nine-bit receive
   task t_rx;
      wb(1'b1, 5'h08, 32'h0000_0001);
      node.put(1'b0, 16);
      wb(1'b1, 5'h00, 32'h0000_0010);
      node.put(1'b0, 15);
      wb(1'b0, 5'h0C, 32'h0000_0000);
      wb(1'b1, 5'h00, 32'h0000_00D0);
      rd(5'h00, 32'h0000_0010, "keep invert");
      node.send(9'h1A5, 9, 1'b1);
      rd(5'h00, 32'h0000_0050, "edge raf");
      rd(5'h04, 32'h0000_0080, "ninth rx");
      rd(5'h0C, 32'h0000_00A5, "rx data");
      $display("test rx done");
   endtask : t_rx
   // Nine-bit transmit, break lengths, inversion, direction
   task t_tx;
      wb(1'b1, 5'h00, 32'h0000_0000);
      wb(1'b1, 5'h04, 32'h0000_0040);
      fork
         node.get(d9, 9);
         wb(1'b1, 5'h0C, 32'h0000_003C);
      join
      chk("tx frame", d9, 32'h0000_013C);
      for (int k = 0; k < 2; k++)
      begin
         wb(1'b1, 5'h00, k ? 32'h0000_0000 : 32'h0000_0004);
         fork
            node.lowlen(n);
            wb(1'b1, 5'h08, k ? 32'h0000_0010 : 32'h0000_0011);
         join
         chk("break len", n, k ? 40 : 56);
      end
      wb(1'b1, 5'h04, 32'h0000_0010);
      repeat (3) @(posedge ref_clk);
      chk("tx inverted", txd_o, 1'b0);
      wb(1'b1, 5'h08, 32'h0000_0006);
      repeat (3) @(posedge ref_clk);
      chk("pin input", txd_oe, 1'b0);
      wb(1'b1, 5'h04, 32'h0000_0020);
      repeat (3) @(posedge ref_clk);
      chk("pin output", txd_oe, 1'b1);
      $display("test tx done");
   endtask : t_tx
   // Reset, then each scenario in turn
   initial
   begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'hF;
      arst_n = 1'b0;
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_lin();
      t_rx();
      t_tx();
      print_verdict();
   end
   // Watchdog far past the expected run
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      n_mismatch++;
      print_verdict();
   end
endmodule : tb
